// >>> lpm_cpu_model.sv
// cpu core model issuing stop and halt instructions
`timescale 1ns/10ps
module lpm_cpu_model (
    input  wire pclk,
    input  wire presetn,
    input  wire req_stop,
    input  wire req_halt,
    input  wire slow,
    output reg  stop_exec,
    output reg  halt_exec,
    output reg  instr_retired
);
    reg [1:0] wait_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_exec <= 1'b0;
            halt_exec <= 1'b0;
            instr_retired <= 1'b0;
            wait_q <= 2'h0;
        end else begin
            stop_exec <= req_stop;
            halt_exec <= req_halt;
            // retires with decode, or two cycles later when slow
            instr_retired <= ((req_stop | req_halt) & !slow) | (wait_q == 2'h1);
            if (req_stop | req_halt)
                wait_q <= slow ? 2'h2 : 2'h0;
            else if (wait_q != 2'h0)
                wait_q <= wait_q - 2'h1;
        end
    end
endmodule

// >>> lpm_ctrl.v
// low-power mode controller: stop/halt sequencing, peripheral power gating and apb registers
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`include "lpm_defines.vh"

// Summary of operation
// - stop instruction puts the device into stop mode
// - entering stop clears the interrupt master enable bit
// - stop halts fast crystal, clears pll enable, releases crystal pins to gpio
// - stop clears fll enable, stops controlled oscillator; it runs after recovery
// - peripheral clock runs in stop per stop-run bit, source and fast recovery
// - enabled real-time clock keeps counting in stop
// - stop halts system clock and cpu, program counter frozen
// - enabled watchdog keeps running in stop
// - timer enabled for stop keeps running from its clock in stop
// - brownout in stop per option bit; low-voltage detect whenever enabled
// - op amps, comparators, temp sensor run in stop only with fast recovery
// - enabled lcd runs in stop; all other peripherals idle
// - halt instruction stops cpu only; clocks and peripherals keep running
// - halt exits on interrupt, watchdog timeout, power-on, brownout or reset pin
// - stop exits only through stop-mode recovery or a system reset
// - clearing a power control bit shuts that block down
// - power control resets to low-voltage detect on only, value 0x10
// - enable bits of absent peripherals have no effect
// - power control reset only by power-on or brownout reset
// - lcd and low-voltage detect stay active in stop regardless of fast recovery
// - fast recovery bit gives quick wake and keeps some blocks alive
// - op amp b bit7, a bit6, temp bit3, comparator 0 bit1, comparator 1 bit0
module lpm_ctrl #(
    parameter [7:0] VARIANT_MASK = `LPM_VARIANT_ALL
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        sys_reset_req,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        stop_exec,
    input  wire        halt_exec,
    input  wire        instr_retired,
    input  wire        irq_pending,
    input  wire        wdt_timeout,
    input  wire        ext_reset_pin,
    input  wire        smr_event,
    input  wire        periph_clock_enable,
    input  wire [1:0]  periph_clock_select,
    input  wire        periph_clock_stop_run,
    input  wire        rtc_enable,
    input  wire        wdt_enable,
    input  wire        timer_stop_enable,
    input  wire        brownout_stop_option,
    output reg  [1:0]  mode,
    output reg         sys_clk_run,
    output reg         cpu_clk_run,
    output reg         interrupt_master_enable_clr,
    output reg         fast_crystal_osc_run,
    output reg         pll_enable_bit_clr,
    output reg         xtal_pins_release,
    output reg         fll_enable_bit_clr,
    output reg         digitally_controlled_osc_run,
    output reg         periph_clock_run,
    output reg         rtc_run,
    output reg         wdt_run,
    output reg         timer_run,
    output reg         brownout_detector_run,
    output reg         low_voltage_detect_on,
    output reg         lcd_on,
    output reg         opamp_a_on,
    output reg         opamp_b_on,
    output reg         temp_sensor_on,
    output reg         comparator_0_on,
    output reg         comparator_1_on,
    output reg         other_periph_run,
    output reg         fast_recovery
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [2:0] ST_RUN       = 3'h0;
    localparam [2:0] ST_STOP_PEND = 3'h1;
    localparam [2:0] ST_HALT_PEND = 3'h2;
    localparam [2:0] ST_STOP      = 3'h3;
    localparam [2:0] ST_HALT      = 3'h4;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [7:0]  pwr_ctrl0_q;
    wire [7:0]  pwr_eff;
    wire        fast_rec_on;
    reg  [31:0] rdata_d;
    wire        in_stop;
    wire        in_halt;
    wire        enter_stop;
    wire        access;
    wire        hit_pwr;
    wire        hit_stat;
    wire        wr_pwr;
    reg         pclk_stop_ok;

    function addr_hit;
        input [31:0] a;
        input [11:0] target;
        begin
            addr_hit = (a[31:12] == 20'h00000) && (a[11:0] == target);
        end
    endfunction

    // an enabled block survives stop only while fast recovery is set
    function stop_keep;
        input en;
        input stopped;
        input fast_rec;
        begin
            stop_keep = en & (~stopped | fast_rec);
        end
    endfunction

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    assign access   = psel & penable & ~pready;
    assign hit_pwr  = addr_hit(paddr, `LPM_PWR_CTRL0_ADDR);
    assign hit_stat = addr_hit(paddr, `LPM_MODE_STAT_ADDR);
    assign wr_pwr   = psel & penable & pready & pwrite & hit_pwr & ~pslverr & pstrb[0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // one wait state on every access
            pready  <= access;
            pslverr <= access & ~(hit_pwr | hit_stat);
        end
    end

    // read data mux, zero for writes and unmapped addresses
    always @* begin
        rdata_d = 32'h00000000;
        if (access & ~pwrite & hit_pwr)
            rdata_d = {24'h000000, pwr_ctrl0_q};
        else if (access & ~pwrite & hit_stat)
            rdata_d = {29'h00000000, state_q};
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h00000000;
        else
            prdata <= rdata_d;
    end

    // ----------------------------------------------------------------
    // power control register (por/brownout reset only)
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_ctrl0_q <= `LPM_PWR_CTRL0_RST;
        end else if (wr_pwr) begin
            pwr_ctrl0_q <= pwdata[7:0];
        end
    end

    // absent blocks are masked so their bits cannot change operation
    assign pwr_eff = pwr_ctrl0_q & VARIANT_MASK;
    assign fast_rec_on = pwr_eff[`LPM_BIT_FAST_REC];

    // ----------------------------------------------------------------
    // mode sequencer
    // ----------------------------------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                // stop wins when both decode together
                if (stop_exec)
                    state_d = instr_retired ? ST_STOP : ST_STOP_PEND;
                else if (halt_exec)
                    state_d = instr_retired ? ST_HALT : ST_HALT_PEND;
            end
            ST_STOP_PEND: begin
                if (instr_retired)
                    state_d = ST_STOP;
            end
            ST_HALT_PEND: begin
                if (instr_retired)
                    state_d = ST_HALT;
            end
            ST_STOP: begin
                if (smr_event)
                    state_d = ST_RUN;
            end
            ST_HALT: begin
                if (irq_pending | wdt_timeout | ext_reset_pin)
                    state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
        // other system resets force run but leave power_control_0 alone
        if (sys_reset_req)
            state_d = ST_RUN;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state_q <= ST_RUN;
        else
            state_q <= state_d;
    end

    assign in_stop    = (state_d == ST_STOP);
    assign in_halt    = (state_d == ST_HALT);
    assign enter_stop = in_stop & (state_q != ST_STOP);

    // ----------------------------------------------------------------
    // peripheral clock in stop
    // ----------------------------------------------------------------
    // source 3 selects no clock, so nothing runs in stop
    always @* begin
        case (periph_clock_select)
            `LPM_PCK_PREC_OSC:
                pclk_stop_ok = periph_clock_stop_run & fast_rec_on;
            `LPM_PCK_SLOW_XTAL:
                pclk_stop_ok = periph_clock_stop_run;
            `LPM_PCK_EXT:
                pclk_stop_ok = periph_clock_stop_run;
            default:
                pclk_stop_ok = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // mode and core clocks
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode        <= `LPM_MODE_RUN;
            sys_clk_run <= 1'b1;
            cpu_clk_run <= 1'b1;
        end else begin
            mode        <= in_stop ? `LPM_MODE_STOP :
                           in_halt ? `LPM_MODE_HALT :
                           `LPM_MODE_RUN;
            // cpu frozen in halt and stop, system clock only in stop
            sys_clk_run <= ~in_stop;
            cpu_clk_run <= ~(in_stop | in_halt);
        end
    end

    // ----------------------------------------------------------------
    // stop entry strobes
    // ----------------------------------------------------------------
    // one-cycle pulses on the first stop cycle only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_master_enable_clr <= 1'b0;
            pll_enable_bit_clr          <= 1'b0;
            fll_enable_bit_clr          <= 1'b0;
        end else begin
            interrupt_master_enable_clr <= enter_stop;
            pll_enable_bit_clr          <= enter_stop;
            fll_enable_bit_clr          <= enter_stop;
        end
    end

    // ----------------------------------------------------------------
    // oscillators and crystal pins
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_crystal_osc_run         <= 1'b1;
            xtal_pins_release            <= 1'b0;
            digitally_controlled_osc_run <= 1'b1;
        end else begin
            fast_crystal_osc_run         <= ~in_stop;
            xtal_pins_release            <= in_stop;
            // restarts on recovery while the fll enable stays cleared
            digitally_controlled_osc_run <= ~in_stop;
        end
    end

    // ----------------------------------------------------------------
    // clocked peripherals
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_clock_run      <= 1'b0;
            rtc_run               <= 1'b0;
            wdt_run               <= 1'b0;
            timer_run             <= 1'b1;
            brownout_detector_run <= 1'b1;
            other_periph_run      <= 1'b1;
        end else begin
            periph_clock_run      <= periph_clock_enable
                                     & (~in_stop | pclk_stop_ok);
            rtc_run               <= rtc_enable;
            wdt_run               <= wdt_enable;
            timer_run             <= ~in_stop | timer_stop_enable;
            brownout_detector_run <= ~in_stop | brownout_stop_option;
            // blocks without their own enable idle in stop
            other_periph_run      <= ~in_stop;
        end
    end

    // ----------------------------------------------------------------
    // power-gated blocks
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_voltage_detect_on <= 1'b0;
            lcd_on                <= 1'b0;
            opamp_a_on            <= 1'b0;
            opamp_b_on            <= 1'b0;
            temp_sensor_on        <= 1'b0;
            comparator_0_on       <= 1'b0;
            comparator_1_on       <= 1'b0;
            fast_recovery         <= 1'b0;
        end else begin
            // a clear bit gates its block; lcd and low-voltage ignore fast recovery
            low_voltage_detect_on <= pwr_eff[`LPM_BIT_LOW_VOLT];
            lcd_on                <= pwr_eff[`LPM_BIT_LCD];
            opamp_a_on            <= stop_keep(pwr_eff[`LPM_BIT_OPAMP_A],
                                               in_stop, fast_rec_on);
            opamp_b_on            <= stop_keep(pwr_eff[`LPM_BIT_OPAMP_B],
                                               in_stop, fast_rec_on);
            temp_sensor_on        <= stop_keep(pwr_eff[`LPM_BIT_TEMP],
                                               in_stop, fast_rec_on);
            comparator_0_on       <= stop_keep(pwr_eff[`LPM_BIT_CMP_0],
                                               in_stop, fast_rec_on);
            comparator_1_on       <= stop_keep(pwr_eff[`LPM_BIT_CMP_1],
                                               in_stop, fast_rec_on);
            fast_recovery         <= fast_rec_on;
        end
    end

endmodule

// >>> lpm_ctrl_monitor.sv
// assertion checker for the low-power mode controller ports
`timescale 1ns/10ps
module lpm_ctrl_monitor (
    input wire       pclk,
    input wire       presetn,
    input wire       sys_reset_req,
    input wire       stop_exec,
    input wire       instr_retired,
    input wire       irq_pending,
    input wire       smr_event,
    input wire [1:0] mode,
    input wire       sys_clk_run,
    input wire       cpu_clk_run,
    input wire       interrupt_master_enable_clr,
    input wire       pll_enable_bit_clr,
    input wire       fll_enable_bit_clr,
    input wire       fast_crystal_osc_run,
    input wire       xtal_pins_release,
    input wire       digitally_controlled_osc_run,
    input wire       other_periph_run,
    input wire       fast_recovery,
    input wire       opamp_a_on,
    input wire       comparator_0_on
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------------------------------
    // mode sequencing
    // ----------------------------------------------------------------
    chk_stop_entry: assert property (
        mode == 2'h0 && stop_exec && instr_retired && !sys_reset_req |=> mode == 2'h2)
        else $error("stop not entered");
    chk_retire_wait: assert property (
        mode == 2'h0 && !instr_retired |=> mode == 2'h0)
        else $error("mode left run before retire");
    chk_ime_clear: assert property (
        mode == 2'h2 && $past(mode) != 2'h2 |-> interrupt_master_enable_clr)
        else $error("interrupt enable not cleared on stop");
    chk_stop_hold: assert property (
        mode == 2'h2 && !smr_event && !sys_reset_req |=> mode == 2'h2)
        else $error("stop left without recovery");
    chk_halt_exit: assert property (
        mode == 2'h1 && (irq_pending || sys_reset_req) |-> ##[1:2] mode == 2'h0)
        else $error("halt not left on wake");
    // ----------------------------------------------------------------
    // clocks and blocks per mode
    // ----------------------------------------------------------------
    chk_stop_clocks: assert property (
        mode == 2'h2 |-> !sys_clk_run && !cpu_clk_run && !other_periph_run)
        else $error("clock running in stop");
    chk_stop_xtal: assert property (
        mode == 2'h2 |-> !fast_crystal_osc_run && xtal_pins_release)
        else $error("crystal active in stop");
    chk_stop_dco: assert property (
        mode == 2'h2 |-> !digitally_controlled_osc_run)
        else $error("controlled oscillator running in stop");
    chk_run_osc: assert property (
        mode != 2'h2 |-> digitally_controlled_osc_run && fast_crystal_osc_run && !xtal_pins_release)
        else $error("oscillators not running outside stop");
    chk_strobe_match: assert property (
        pll_enable_bit_clr == interrupt_master_enable_clr
        && fll_enable_bit_clr == interrupt_master_enable_clr)
        else $error("stop entry strobes differ");
    chk_strobe_pulse: assert property (
        interrupt_master_enable_clr |=> !interrupt_master_enable_clr)
        else $error("stop entry strobe longer than one cycle");
    chk_halt_clocks: assert property (
        mode == 2'h1 |-> sys_clk_run && !cpu_clk_run && other_periph_run)
        else $error("halt clocks wrong");
    chk_fast_rec_gate: assert property (
        mode == 2'h2 && !fast_recovery |-> !opamp_a_on && !comparator_0_on)
        else $error("analog block on in stop without fast recovery");
    cover property (mode == 2'h2 && fast_recovery);
    cover property (mode == 2'h2 && irq_pending);
    cover property (mode == 2'h1 && sys_reset_req);
endmodule

bind lpm_ctrl lpm_ctrl_monitor u_mon (.pclk(pclk), .presetn(presetn),
    .sys_reset_req(sys_reset_req), .stop_exec(stop_exec), .instr_retired(instr_retired),
    .irq_pending(irq_pending), .smr_event(smr_event), .mode(mode),
    .sys_clk_run(sys_clk_run), .cpu_clk_run(cpu_clk_run),
    .interrupt_master_enable_clr(interrupt_master_enable_clr),
    .pll_enable_bit_clr(pll_enable_bit_clr), .fll_enable_bit_clr(fll_enable_bit_clr),
    .fast_crystal_osc_run(fast_crystal_osc_run), .xtal_pins_release(xtal_pins_release),
    .digitally_controlled_osc_run(digitally_controlled_osc_run),
    .other_periph_run(other_periph_run), .fast_recovery(fast_recovery),
    .opamp_a_on(opamp_a_on), .comparator_0_on(comparator_0_on));

// >>> lpm_ctrl_tb_top.sv
// self-checking bench for the low-power mode controller
`timescale 1ns/10ps
`include "lpm_defines.vh"
module lpm_ctrl_tb_top;
    localparam [31:0] A_PWR = {20'h0, `LPM_PWR_CTRL0_ADDR};
    reg        pclk, presetn, psel, penable, pwrite, req_stop, req_halt, slow, er;
    reg        pck_en, pck_sr, rtc_en, wdt_en, tmr_en, bo_opt;
    reg [1:0]  pck_sel;
    reg [3:0]  pstrb;
    reg [4:0]  wake;
    reg [7:0]  lf, mdl_reg;
    reg [1:0]  mdl_mode;
    reg [31:0] paddr, pwdata, rd;
    integer    fails, cmp_count, cyc, i;
    wire [31:0] prdata;
    wire [16:0] obs;
    wire       pready, pslverr, stop_exec, halt_exec, retired, pck_run;
    lpm_cpu_model CPU (.pclk(pclk), .presetn(presetn), .req_stop(req_stop),
        .req_halt(req_halt), .slow(slow), .stop_exec(stop_exec), .halt_exec(halt_exec),
        .instr_retired(retired));
    lpm_ctrl DUT (.pclk(pclk), .presetn(presetn), .sys_reset_req(wake[3]), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_exec(stop_exec),
        .halt_exec(halt_exec), .instr_retired(retired), .irq_pending(wake[0]),
        .wdt_timeout(wake[1]), .ext_reset_pin(wake[2]), .smr_event(wake[4]),
        .periph_clock_enable(pck_en), .periph_clock_select(pck_sel),
        .periph_clock_stop_run(pck_sr), .rtc_enable(rtc_en), .wdt_enable(wdt_en),
        .timer_stop_enable(tmr_en), .brownout_stop_option(bo_opt), .mode(obs[16:15]),
        .sys_clk_run(obs[14]), .cpu_clk_run(obs[13]), .interrupt_master_enable_clr(),
        .fast_crystal_osc_run(), .pll_enable_bit_clr(), .xtal_pins_release(),
        .fll_enable_bit_clr(), .digitally_controlled_osc_run(), .periph_clock_run(pck_run),
        .rtc_run(obs[3]), .wdt_run(obs[2]), .timer_run(obs[1]), .brownout_detector_run(obs[0]),
        .low_voltage_detect_on(obs[11]), .lcd_on(obs[12]), .opamp_a_on(obs[9]),
        .opamp_b_on(obs[10]), .temp_sensor_on(obs[8]), .comparator_0_on(obs[7]),
        .comparator_1_on(obs[6]), .other_periph_run(obs[5]), .fast_recovery(obs[4]));
    // ----------------------------------------------------------------
    // model, compares and bus tasks
    // ----------------------------------------------------------------
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function [16:0] exp_obs;
        reg       s;
        reg [7:0] g;
        begin
            s = (mdl_mode == 2'h2);
            g = mdl_reg & {8{!s | mdl_reg[2]}};
            exp_obs = {mdl_mode, !s, mdl_mode == 2'h0, mdl_reg[5:4], g[7], g[6], g[3], g[1],
                       g[0], !s, mdl_reg[2], rtc_en, wdt_en, s ? tmr_en : 1'b1, s ? bo_opt : 1'b1};
        end
    endfunction
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task cmp_obs;
        cmp({15'h0, obs}, {15'h0, exp_obs()});
    endtask
    task apb(input wr, input [31:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task wait_mode(input [1:0] m);
        for (i = i; obs[16:15] !== m && cyc < 3000; i = i) @(posedge pclk);
        mdl_mode = m;
    endtask
    task run_op(input st, input [1:0] m);
        begin
            req_stop <= st;
            req_halt <= !st;
            slow <= lf[0];
            @(posedge pclk);
            req_stop <= 1'b0;
            req_halt <= 1'b0;
            wait_mode(m);
        end
    endtask
    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, fails);
            if (fails == 0 && cmp_count > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc > 3000) begin
            fails = fails + 1;
            end_sim;
        end
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, req_stop, req_halt, slow, wake} = 12'h0;
        {pck_en, pck_sr, pck_sel, rtc_en, wdt_en, tmr_en, bo_opt} = 8'h0;
        {paddr, pwdata, pstrb} = {64'h0, 4'hf};
        {fails, cmp_count, cyc, i} = {32'd0, 32'd0, 32'd0, 32'd0};
        {lf, mdl_reg, mdl_mode} = {8'd39, 8'h10, 2'h0};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, A_PWR, 32'h0);
        cmp(rd, 32'h10);
        cmp_obs;
        for (i = 0; i < 4; i = i + 1) begin
            lf = lfsr(lf);
            apb(1'b1, A_PWR, {24'hffffff, lf});
            mdl_reg = lf;
            apb(1'b0, A_PWR, 32'h0);
            cmp(rd, {24'h0, lf});
            cmp_obs;
        end
        pstrb <= 4'he;
        apb(1'b1, A_PWR, 32'h0);
        pstrb <= 4'hf;
        apb(1'b1, 32'hf88, 32'h0);
        cmp({31'h0, er}, 32'h1);
        wake <= 5'h08;
        @(posedge pclk);
        wake <= 5'h00;
        apb(1'b0, A_PWR, 32'h0);
        cmp(rd, {24'h0, mdl_reg});
        $display("register test done");
        for (i = 0; i < 2; i = i + 1) begin
            lf = lfsr(lf);
            {pck_en, pck_sr, pck_sel, rtc_en, wdt_en, tmr_en, bo_opt} <= lf | 8'hc0;
            mdl_reg = i ? 8'hff : 8'hfb;
            apb(1'b1, A_PWR, {24'h0, mdl_reg});
            run_op(1'b1, 2'h2);
            cmp_obs;
            cmp({31'h0, pck_run}, {31'h0, pck_sel == 2'h1 || pck_sel == 2'h2 ||
                (pck_sel == 2'h0 && mdl_reg[2])});
            apb(1'b0, {20'h0, `LPM_MODE_STAT_ADDR}, 32'h0);
            cmp(rd, 32'h3);
            wake <= 5'h01;
            repeat (3) @(posedge pclk);
            cmp_obs;
            wake <= 5'h10;
            wait_mode(2'h0);
            wake <= 5'h00;
            cmp_obs;
        end
        $display("stop test done");
        for (i = 0; i < 4; i = i + 1) begin
            lf = lfsr(lf);
            run_op(1'b0, 2'h1);
            cmp_obs;
            wake <= 5'h01 << i;
            wait_mode(2'h0);
            wake <= 5'h00;
            cmp_obs;
        end
        $display("halt test done");
        run_op(1'b1, 2'h2);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        {mdl_reg, mdl_mode} = {8'h10, 2'h0};
        @(posedge pclk);
        apb(1'b0, A_PWR, 32'h0);
        cmp(rd, 32'h10);
        cmp_obs;
        $display("power-on reset test done");
        end_sim;
    end
endmodule

// >>> lpm_defines.vh
// register map, field positions, reset values and encodings of the low-power mode controller
`ifndef LPM_DEFINES_VH
`define LPM_DEFINES_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define LPM_ADDR_W          12
`define LPM_PWR_CTRL0_ADDR  12'hf80
`define LPM_MODE_STAT_ADDR  12'hf84

// ----------------------------------------------------------------
// power_control_0 fields
// ----------------------------------------------------------------
`define LPM_BIT_OPAMP_B     7
`define LPM_BIT_OPAMP_A     6
`define LPM_BIT_LCD         5
`define LPM_BIT_LOW_VOLT    4
`define LPM_BIT_TEMP        3
`define LPM_BIT_FAST_REC    2
`define LPM_BIT_CMP_0       1
`define LPM_BIT_CMP_1       0
`define LPM_PWR_CTRL0_RST   8'h10
`define LPM_VARIANT_ALL     8'hff

// ----------------------------------------------------------------
// mode output encodings (the status register returns the 3-bit sequencer state in bits [2:0])
// ----------------------------------------------------------------
`define LPM_MODE_RUN        2'h0
`define LPM_MODE_HALT       2'h1
`define LPM_MODE_STOP       2'h2

// ----------------------------------------------------------------
// peripheral clock source select
// ----------------------------------------------------------------
`define LPM_PCK_PREC_OSC    2'h0
`define LPM_PCK_SLOW_XTAL   2'h1
`define LPM_PCK_EXT         2'h2

`endif
